// ===== verilog/dio_pkg.sv
package dio_pkg;
  // Port registers: high nibble direction, low nibble pin data
  localparam logic [7:0] PORT0_ADDR = 8'h80;
  localparam logic [7:0] PORT1_ADDR = 8'h90;
  localparam logic [7:0] PORT2_ADDR = 8'hA0;
  localparam logic [7:0] PORT3_ADDR = 8'hB0;
  localparam int PORT_COUNT = 4;
  localparam int PORT_PINS = 4;
  localparam int LOW_PINS = 16;
  localparam int DIR_LSB = 4;
  localparam int DATA_LSB = 0;
  localparam logic [15:0] DIR_RESET = 16'hFFFF;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // Pins above the first sixteen, run by their own segment-pin controls
  localparam int HIGH_PINS = 8;
  localparam int SEG_DATA_BIT = 0;
  localparam int SEG_DIR_BIT = 1;

  // Route registers in the I/O RAM space
  localparam logic [15:0] PUSHBUTTON_ROUTE_ADDR = 16'h2450;
  localparam logic [15:0] PIN10_11_ROUTE_ADDR = 16'h2451;
  localparam logic [15:0] PIN8_9_ROUTE_ADDR = 16'h2452;
  localparam logic [15:0] PIN6_7_ROUTE_ADDR = 16'h2453;
  localparam logic [15:0] PIN4_5_ROUTE_ADDR = 16'h2454;
  localparam logic [15:0] PIN2_3_ROUTE_ADDR = 16'h2455;
  localparam int ROUTE_LO_LSB = 0;
  localparam int ROUTE_HI_LSB = 4;
  localparam int ROUTE_W = 3;
  localparam logic [2:0] ROUTE_RESET = 3'h0;
  localparam int ROUTED_PINS = 10;
  localparam int FIRST_ROUTED_PIN = 2;

  typedef enum logic [2:0] {
    ROUTE_NONE = 3'b000,
    ROUTE_RESERVED = 3'b001,
    ROUTE_TIMER0 = 3'b010,
    ROUTE_TIMER1 = 3'b011,
    ROUTE_EXTERNAL_INTERRUPT_ZERO = 3'b100,
    ROUTE_EXTERNAL_INTERRUPT_ONE = 3'b101
  } route_code_t;
endpackage

// ===== verilog/dio_pin_routing_and_port.sv
`timescale 1ns/100ps
// Function
// - Three-bit route fields tie pins two to eleven and pushbutton to resources.
// - Code 2 feeds the pin to timer0 clock or gate, ORed.
// - Code 3 feeds the pin to timer1 clock or gate, ORed.
// - Code 4 routes the pin to external interrupt zero, ORed.
// - Code 5 routes the pin to external interrupt one, ORed.
// - One direction bit per low pin, one means output, reset ones.
// - Direction bit ignored when the pin is not general I/O.
// - High pins take direction from segment-pin control bit one.
// - Data reads return pin levels; LCD pins read zero.
// - Data writes change the driven level only on output pins.
// - LCD and input pins ignore writes to their data bits.
// - High pins take output data from segment-pin control bit zero.
module dio_pin_routing_and_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [15:0] xram_addr,
  input wire logic xram_wr,
  input wire logic xram_rd,
  input wire logic [7:0] xram_wdata,
  output logic [7:0] xram_rdata,
  input wire logic [dio_pkg::LOW_PINS-1:0] lcd_sel,
  input wire logic [dio_pkg::LOW_PINS-1:0] pin_in,
  output logic [dio_pkg::LOW_PINS-1:0] pin_out,
  output logic [dio_pkg::LOW_PINS-1:0] pin_oe_n,
  input wire logic pushbutton_in,
  input wire logic [dio_pkg::HIGH_PINS-1:0] high_lcd_sel,
  input wire logic [dio_pkg::HIGH_PINS-1:0][1:0] segment_pin_control,
  output logic [dio_pkg::HIGH_PINS-1:0] high_pin_out,
  output logic [dio_pkg::HIGH_PINS-1:0] high_pin_oe_n,
  output logic timer0_clock_gate,
  output logic timer1_clock_gate,
  output logic external_interrupt_zero,
  output logic external_interrupt_one
);
  import dio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [1:0] port_hit(input logic [7:0] addr, output logic hit);
    hit = 1'b1;
    case (addr)
      PORT0_ADDR: port_hit = 2'h0;
      PORT1_ADDR: port_hit = 2'h1;
      PORT2_ADDR: port_hit = 2'h2;
      PORT3_ADDR: port_hit = 2'h3;
      default: begin
        port_hit = 2'h0;
        hit = 1'b0;
      end
    endcase
  endfunction

  // Only codes 2..5 reach a resource; 0, 1 and 6..7 reach nothing
  function automatic logic route_match(input logic [2:0] field, input route_code_t code);
    route_match = (field == code);
  endfunction

  // Spare bits 3 and 7 of a route byte always read zero
  function automatic logic [7:0] route_pair(input logic [ROUTE_W-1:0] lo, input logic [ROUTE_W-1:0] hi);
    route_pair = 8'h00;
    route_pair[ROUTE_LO_LSB +: ROUTE_W] = lo;
    route_pair[ROUTE_HI_LSB +: ROUTE_W] = hi;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [LOW_PINS-1:0] pin_meta;
  logic [LOW_PINS-1:0] pin_sync;
  logic pb_meta;
  logic pb_sync;

  // Two stages: pins and pushbutton are asynchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pb_meta <= 1'b0;
      pb_sync <= 1'b0;
    end else if (ce) begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pb_meta <= pushbutton_in;
      pb_sync <= pb_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port direction and data

  logic [LOW_PINS-1:0] pin_direction_bits;
  logic [LOW_PINS-1:0] pin_data_bits;
  logic [LOW_PINS-1:0] gpio_out;
  logic [1:0] wr_port;
  logic wr_hit;
  logic [1:0] rd_port;
  logic rd_hit;

  always_comb begin
    wr_port = port_hit(sfr_addr, wr_hit);
    rd_port = port_hit(sfr_addr, rd_hit);
  end

  // Pin is an active output only when general I/O and direction is one
  assign gpio_out = pin_direction_bits & ~lcd_sel;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_direction_bits <= DIR_RESET;
    end else if (ce && sfr_wr && wr_hit) begin
      pin_direction_bits[wr_port*PORT_PINS +: PORT_PINS] <= sfr_wdata[DIR_LSB +: PORT_PINS];
    end
  end

  // Mask uses the direction before this write, so a write that also flips
  // direction does not leak data onto a pin that was an input.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_data_bits <= DATA_RESET;
    end else if (ce && sfr_wr && wr_hit) begin
      for (int i = 0; i < PORT_PINS; i++) begin
        if (gpio_out[wr_port*PORT_PINS + i]) begin
          pin_data_bits[wr_port*PORT_PINS + i] <= sfr_wdata[DATA_LSB + i];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else if (ce) begin
      pin_out <= pin_data_bits & gpio_out;
      pin_oe_n <= ~gpio_out;
    end
  end

  // Unmapped SFR reads answer zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_rd) begin
      if (rd_hit) begin
        sfr_rdata <= {pin_direction_bits[rd_port*PORT_PINS +: PORT_PINS],
                      pin_sync[rd_port*PORT_PINS +: PORT_PINS] & ~lcd_sel[rd_port*PORT_PINS +: PORT_PINS]};
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // High pins follow their own segment-pin controls

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_pin_out <= '0;
    end else if (ce) begin
      for (int i = 0; i < HIGH_PINS; i++) begin
        high_pin_out[i] <= segment_pin_control[i][SEG_DATA_BIT] & ~high_lcd_sel[i];
      end
    end
  end

  // LCD select wins over the direction bit of a high pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_pin_oe_n <= '1;
    end else if (ce) begin
      for (int i = 0; i < HIGH_PINS; i++) begin
        high_pin_oe_n[i] <= ~(segment_pin_control[i][SEG_DIR_BIT] & ~high_lcd_sel[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Route fields: index 0..9 are pins 2..11, index 10 is the pushbutton

  logic [ROUTED_PINS:0][ROUTE_W-1:0] route_field;
  logic [ROUTED_PINS:0] route_src;
  logic route_hit;
  logic [15:0] route_addr;

  assign route_src = {pb_sync, pin_sync[FIRST_ROUTED_PIN +: ROUTED_PINS]};

  always_comb begin
    route_hit = 1'b1;
    case (xram_addr)
      PUSHBUTTON_ROUTE_ADDR, PIN10_11_ROUTE_ADDR, PIN8_9_ROUTE_ADDR,
      PIN6_7_ROUTE_ADDR, PIN4_5_ROUTE_ADDR, PIN2_3_ROUTE_ADDR: route_hit = 1'b1;
      default: route_hit = 1'b0;
    endcase
    route_addr = xram_addr;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      route_field <= '0;
    end else if (ce && xram_wr && route_hit) begin
      case (route_addr)
        PUSHBUTTON_ROUTE_ADDR: begin
          route_field[10] <= xram_wdata[ROUTE_LO_LSB +: ROUTE_W];
        end
        PIN10_11_ROUTE_ADDR: begin
          route_field[8] <= xram_wdata[ROUTE_LO_LSB +: ROUTE_W];
          route_field[9] <= xram_wdata[ROUTE_HI_LSB +: ROUTE_W];
        end
        PIN8_9_ROUTE_ADDR: begin
          route_field[6] <= xram_wdata[ROUTE_LO_LSB +: ROUTE_W];
          route_field[7] <= xram_wdata[ROUTE_HI_LSB +: ROUTE_W];
        end
        PIN6_7_ROUTE_ADDR: begin
          route_field[4] <= xram_wdata[ROUTE_LO_LSB +: ROUTE_W];
          route_field[5] <= xram_wdata[ROUTE_HI_LSB +: ROUTE_W];
        end
        PIN4_5_ROUTE_ADDR: begin
          route_field[2] <= xram_wdata[ROUTE_LO_LSB +: ROUTE_W];
          route_field[3] <= xram_wdata[ROUTE_HI_LSB +: ROUTE_W];
        end
        PIN2_3_ROUTE_ADDR: begin
          route_field[0] <= xram_wdata[ROUTE_LO_LSB +: ROUTE_W];
          route_field[1] <= xram_wdata[ROUTE_HI_LSB +: ROUTE_W];
        end
        default: begin
        end
      endcase
    end
  end

  // Unmapped I/O RAM reads answer zero; unused bits read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xram_rdata <= 8'h00;
    end else if (ce && xram_rd) begin
      case (xram_addr)
        PUSHBUTTON_ROUTE_ADDR: begin
          xram_rdata <= route_pair(route_field[10], ROUTE_RESET);
        end
        PIN10_11_ROUTE_ADDR: begin
          xram_rdata <= route_pair(route_field[8], route_field[9]);
        end
        PIN8_9_ROUTE_ADDR: begin
          xram_rdata <= route_pair(route_field[6], route_field[7]);
        end
        PIN6_7_ROUTE_ADDR: begin
          xram_rdata <= route_pair(route_field[4], route_field[5]);
        end
        PIN4_5_ROUTE_ADDR: begin
          xram_rdata <= route_pair(route_field[2], route_field[3]);
        end
        PIN2_3_ROUTE_ADDR: begin
          xram_rdata <= route_pair(route_field[0], route_field[1]);
        end
        default: xram_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Resource combining: any mapped pin high drives the resource high

  logic next_t0;
  logic next_t1;
  logic next_i0;
  logic next_i1;

  always_comb begin
    next_t0 = 1'b0;
    next_t1 = 1'b0;
    next_i0 = 1'b0;
    next_i1 = 1'b0;
    for (int i = 0; i <= ROUTED_PINS; i++) begin
      next_t0 = next_t0 | (route_src[i] & route_match(route_field[i], ROUTE_TIMER0));
      next_t1 = next_t1 | (route_src[i] & route_match(route_field[i], ROUTE_TIMER1));
      next_i0 = next_i0 | (route_src[i] & route_match(route_field[i], ROUTE_EXTERNAL_INTERRUPT_ZERO));
      next_i1 = next_i1 | (route_src[i] & route_match(route_field[i], ROUTE_EXTERNAL_INTERRUPT_ONE));
    end
  end

  // Registered so the timers and interrupts see a glitch-free OR
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer0_clock_gate <= 1'b0;
      timer1_clock_gate <= 1'b0;
      external_interrupt_zero <= 1'b0;
      external_interrupt_one <= 1'b0;
    end else if (ce) begin
      timer0_clock_gate <= next_t0;
      timer1_clock_gate <= next_t1;
      external_interrupt_zero <= next_i0;
      external_interrupt_one <= next_i1;
    end
  end
endmodule

// ===== tb/dio_pin_ext.sv
`timescale 1ns/100ps
module dio_pin_ext (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] ext_drive,
  output logic [15:0] pin_in
);
  // Released pins follow the outside driver
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_drive);
endmodule

// ===== tb/dio_pin_routing_and_port_properties.sv
`timescale 1ns/100ps
module dio_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic [15:0] xram_addr,
  input wire logic xram_rd,
  input wire logic xram_wr,
  input wire logic [7:0] xram_rdata,
  input wire logic [15:0] lcd_sel,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic [7:0] high_lcd_sel,
  input wire logic [7:0][1:0] segment_pin_control,
  input wire logic [7:0] high_pin_out,
  input wire logic [7:0] high_pin_oe_n,
  input wire logic timer0_clock_gate
);
  import dio_pkg::*;
  logic [7:0] hi_d, hi_oe;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      hi_d[i] = segment_pin_control[i][0] & ~high_lcd_sel[i];
      hi_oe[i] = ~(segment_pin_control[i][1] & ~high_lcd_sel[i]);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  property p_lcd_oe; ce |=> &(pin_oe_n | ~$past(lcd_sel)); endproperty
  a_lcd_oe: assert property (p_lcd_oe) else $error("lcd pin driven");
  property p_lcd_out; ce |=> (pin_out & $past(lcd_sel)) == 16'h0000; endproperty
  a_lcd_out: assert property (p_lcd_out) else $error("lcd pin level set");
  property p_drv; (pin_out & pin_oe_n) == 16'h0000; endproperty
  a_drv: assert property (p_drv) else $error("level on released pin");
  property p_hi_out; ce |=> high_pin_out == $past(hi_d); endproperty
  a_hi_out: assert property (p_hi_out) else $error("high pin data wrong");
  property p_hi_oe; ce |=> high_pin_oe_n == $past(hi_oe); endproperty
  a_hi_oe: assert property (p_hi_oe) else $error("high pin drive wrong");
  property p_rd_lcd;
    ce && sfr_rd && sfr_addr == PORT0_ADDR |=> ($past(lcd_sel) & {12'h000, sfr_rdata[3:0]}) == 16'h0000;
  endproperty
  a_rd_lcd: assert property (p_rd_lcd) else $error("lcd pin read nonzero");
  property p_pb; ce && xram_rd && xram_addr == PUSHBUTTON_ROUTE_ADDR |=> xram_rdata[7:3] == 5'h00; endproperty
  a_pb: assert property (p_pb) else $error("route spare bits set");
  property p_hold; !(ce && sfr_rd) |=> $stable(sfr_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_sfr: cover property (ce && sfr_rd);
  c_route: cover property (ce && xram_wr);
  c_t0: cover property ($rose(timer0_clock_gate));
endmodule
bind dio_pin_routing_and_port dio_props u_props (.clk(clk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .xram_addr(xram_addr), .xram_rd(xram_rd), .xram_wr(xram_wr),
  .xram_rdata(xram_rdata), .lcd_sel(lcd_sel), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .high_lcd_sel(high_lcd_sel), .segment_pin_control(segment_pin_control), .high_pin_out(high_pin_out),
  .high_pin_oe_n(high_pin_oe_n), .timer0_clock_gate(timer0_clock_gate));

// ===== tb/dio_pin_routing_and_port_tb.sv
`timescale 1ns/100ps
module dio_pin_routing_and_port_tb;
  import dio_pkg::*;
  logic clk = 0, rst = 1, ce = 1, sfr_wr = 0, sfr_rd = 0, xram_wr = 0, xram_rd = 0, pb = 0;
  logic t0, t1, i0, i1;
  logic [7:0] sfr_addr = 0, wdata = 0, sfr_rdata, xram_rdata, hl = 0, hpo, hoe, r, hd, ho;
  logic [15:0] xram_addr = 0, lcd = 0, pin_in, pin_out, pin_oe_n, ext = 0, dir, dat;
  logic [7:0][1:0] seg = 0;
  logic [8:0] e;
  logic [8:0] q[$];
  int fails = 0, num_checks = 0, cyc = 0, seed = 32'hbe4f;
  dio_pin_routing_and_port u_dut (.clk(clk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(wdata), .sfr_rdata(sfr_rdata), .xram_addr(xram_addr), .xram_wr(xram_wr),
    .xram_rd(xram_rd), .xram_wdata(wdata), .xram_rdata(xram_rdata), .lcd_sel(lcd), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pushbutton_in(pb), .high_lcd_sel(hl), .segment_pin_control(seg),
    .high_pin_out(hpo), .high_pin_oe_n(hoe), .timer0_clock_gate(t0), .timer1_clock_gate(t1),
    .external_interrupt_zero(i0), .external_interrupt_one(i1));
  dio_pin_ext u_ext (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_drive(ext), .pin_in(pin_in));
  initial begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic bus(input bit x, input bit wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a[7:0];
    xram_addr = a;
    wdata = d;
    {xram_wr, sfr_wr, xram_rd, sfr_rd} = {x & wr, !x & wr, x & !wr, !x & !wr};
    @(negedge clk);
    {xram_wr, sfr_wr, xram_rd, sfr_rd} = 4'h0;
  endtask
  task automatic rd(input bit x, input logic [15:0] a, input logic [7:0] exp);
    q.push_back({x, exp});
    bus(x, 0, a, 8'h00);
  endtask
  // Model masks data with the direction held before the write
  task automatic wport(input int p, input logic [7:0] d);
    for (int i = 0; i < 4; i++) begin
      if (dir[p*4+i] && !lcd[p*4+i]) dat[p*4+i] = d[i];
      dir[p*4+i] = d[4+i];
    end
    bus(0, 1, 16'(PORT0_ADDR + 8'(p * 16)), d);
  endtask
  function automatic logic [7:0] pexp(input int p);
    logic [3:0] v;
    for (int i = 0; i < 4; i++) begin
      v[i] = !lcd[p*4+i] && (dir[p*4+i] ? dat[p*4+i] : ext[p*4+i]);
    end
    return {dir[p*4+:4], v};
  endfunction
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (sfr_rd || xram_rd) begin
      #1;
      e = q.pop_front();
      check(e[8] ? xram_rdata : sfr_rdata, e[7:0]);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    dir = DIR_RESET;
    dat = DATA_RESET;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 0;
    for (int p = 0; p < 4; p++) rd(0, 16'(PORT0_ADDR + 8'(p * 16)), pexp(p));
    rd(0, 16'h00C0, 8'h00);
    for (int k = 0; k < 40; k++) begin
      {lcd, ext} = $random(seed);
      {hl, seg, r} = $random(seed);
      wport(k % 4, r);
      repeat (4) @(negedge clk);
      rd(0, 16'(PORT0_ADDR + 8'(k % 4 * 16)), pexp(k % 4));
      for (int i = 0; i < 8; i++) begin
        hd[i] = seg[i][0];
        ho[i] = seg[i][1];
      end
      check(hpo, hd & ~hl);
      check(hoe, ~(ho & ~hl));
    end
    // Pins eight to eleven as inputs for routing
    lcd = 16'h0000;
    wport(2, 8'h00);
    ext = 16'h0100;
    for (int c = 0; c < 8; c++) begin
      bus(1, 1, PIN8_9_ROUTE_ADDR, 8'(c));
      repeat (4) @(negedge clk);
      check({4'h0, t0, t1, i0, i1}, {4'h0, c == 2, c == 3, c == 4, c == 5});
      rd(1, PIN8_9_ROUTE_ADDR, 8'(c));
    end
    bus(1, 1, PUSHBUTTON_ROUTE_ADDR, 8'hFA);
    bus(1, 1, PIN8_9_ROUTE_ADDR, 8'h20);
    rd(1, PUSHBUTTON_ROUTE_ADDR, 8'h02);
    for (int c = 0; c < 4; c++) begin
      // Pin eight held high but unrouted; pushbutton and pin nine feed timer0
      {pb, ext[9], ext[8]} = {2'(c), 1'b1};
      repeat (4) @(negedge clk);
      check({7'h0, t0}, {7'h0, c != 0});
    end
    // Every route byte: odd pins to interrupt zero, even pins and pushbutton to one
    wport(0, 8'h00);
    wport(1, 8'h00);
    for (int a = 0; a < 6; a++) begin
      bus(1, 1, PUSHBUTTON_ROUTE_ADDR + 16'(a), 8'hCD);
      rd(1, PUSHBUTTON_ROUTE_ADDR + 16'(a), (a == 0) ? 8'h05 : 8'h45);
    end
    for (int c = 0; c < 2; c++) begin
      {pb, ext} = {c == 1, (c == 0) ? 16'h0808 : 16'h0004};
      repeat (4) @(negedge clk);
      check({4'h0, t0, t1, i0, i1}, {6'h00, c == 0, c == 1});
    end
    // Clock enable low must drop a route write
    ce = 0;
    bus(1, 1, PIN2_3_ROUTE_ADDR, 8'h00);
    ce = 1;
    rd(1, PIN2_3_ROUTE_ADDR, 8'h45);
    repeat (2) @(negedge clk);
    give_verdict();
  end
endmodule
